// ### inc/rtcal_pkg.sv
// constants, field positions and state type of the calendar and alarm register block
package rtcal_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned RTC_HZ        = 32_768;
  localparam int unsigned RTC_DIV       = CLK_HZ / RTC_HZ;
  localparam int unsigned HALF_SEC_CLKS = 16_384;
  localparam int unsigned SAFE_CLKS     = 32;

  localparam logic [4:0] OFS_CTRL  = 5'h00;
  localparam logic [4:0] OFS_ALRM  = 5'h04;
  localparam logic [4:0] OFS_TIME  = 5'h08;
  localparam logic [4:0] OFS_DATE  = 5'h0C;
  localparam logic [4:0] OFS_ATIME = 5'h10;

  localparam int CC_ON     = 15;
  localparam int CC_UNLOCK = 3;
  localparam int CC_SYNC   = 2;
  localparam int CC_HALF   = 1;
  localparam int AL_EN     = 15;
  localparam int AL_CHIME  = 14;
  localparam int AL_PIV    = 13;
  localparam int AL_SYNC   = 12;
  localparam int AL_MASK   = 8;
  localparam int AL_RPT    = 0;

  localparam int HR_LSB  = 24;
  localparam int MIN_LSB = 16;
  localparam int SEC_LSB = 8;
  localparam int YR_LSB  = 24;
  localparam int MON_LSB = 16;
  localparam int DAY_LSB = 8;
  localparam int WD_LSB  = 0;

  localparam logic [31:0] TIME_MASK = 32'hFFFF_FF00;
  localparam logic [31:0] DATE_MASK = 32'hFFFF_FF0F;

  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] MIN_MAX = 8'h59;
  localparam logic [7:0] HR_MAX  = 8'h23;
  localparam logic [7:0] MON_MAX = 8'h12;
  localparam logic [7:0] YR_MAX  = 8'h99;
  localparam logic [3:0] WD_MAX  = 4'h6;
  localparam logic [7:0] RPT_MAX = 8'hFF;

  localparam logic [3:0] MASK_HALF = 4'h0;
  localparam logic [3:0] MASK_SEC  = 4'h1;
  localparam logic [3:0] MASK_10S  = 4'h2;
  localparam logic [3:0] MASK_MIN  = 4'h3;
  localparam logic [3:0] MASK_10M  = 4'h4;
  localparam logic [3:0] MASK_HOUR = 4'h5;
  localparam logic [3:0] MASK_DAY  = 4'h6;

  typedef struct packed {
    logic        on;
    logic        unlock;
    logic        half;
    logic [14:0] presc;
    logic [9:0]  rdiv;
    logic [31:0] tm;
    logic [31:0] dt;
    logic [31:0] atm;
    logic        alrm_en;
    logic        chime;
    logic        piv;
    logic [3:0]  amask;
    logic [7:0]  rpt;
    logic        pulse;
    logic        waitreq;
    logic [31:0] rdata;
  } rtcal_state_t;

  localparam rtcal_state_t ST_RST = '{waitreq: 1'b1, default: '0};
endpackage

// ### rtl/rtcal_regs.sv
// calendar value registers, alarm repeat logic and avalon-mm slave
`timescale 1ns/10ps
module rtcal_regs #(
  parameter int unsigned HALF_SEC_CLKS = rtcal_pkg::HALF_SEC_CLKS
) (
  input  wire logic        mclk,            // 20 MHz clock
  input  wire logic        srst,            // general reset, sync
  input  wire logic        por,             // power-on reset, sync
  input  wire logic [4:0]  avs_address,     // byte address
  input  wire logic        avs_read,        // read request
  input  wire logic        avs_write,       // write request
  input  wire logic [31:0] avs_writedata,   // write data
  input  wire logic [3:0]  avs_byteenable,  // byte lanes
  output logic      [31:0] avs_readdata,    // read data
  output logic             avs_waitrequest, // stall, low = answer
  output logic             alarm_pulse      // alarm pulse level
);
  import rtcal_pkg::*;

  localparam logic [14:0] HALF_LAST = 15'(HALF_SEC_CLKS - 1);
  localparam logic [14:0] SAFE_EDGE = 15'(HALF_SEC_CLKS - SAFE_CLKS);
  localparam logic [9:0]  DIV_LAST  = 10'(RTC_DIV - 1);

  rtcal_state_t st_q;
  rtcal_state_t st_d;
  rtcal_state_t keep;
  logic         rtc_en;
  logic         hs_tick;
  logic         sec_tick;
  logic         unsafe;
  logic         alarm_evt;
  logic         wr_go;
  logic         req;
  logic [31:0]  t_nx;
  logic [31:0]  d_nx;
  logic [31:0]  ctrl_v;
  logic [31:0]  alrm_v;
  logic [31:0]  rd_mux;
  logic [31:0]  wv;
  logic [8:0]   c_s;
  logic [8:0]   c_m;
  logic [8:0]   c_h;
  logic [8:0]   c_d;
  logic [8:0]   c_mo;
  logic [8:0]   c_y;

  // increment a BCD pair; carry out and reload at the top value
  function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                         input logic [7:0] top,
                                         input logic [7:0] base);
    if (v >= top) begin
      return {1'b1, base};
    end
    if (v[3:0] == 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return {1'b0, v + 8'h01};
  endfunction

  // last day of month in BCD; leap test on a two digit year only
  function automatic logic [7:0] month_days(input logic [7:0] mon,
                                            input logic [7:0] yr);
    logic leap;
    leap = (2'({yr[4], 1'b0} + yr[1:0]) == 2'b00);
    case (mon)
      8'h02: begin
        return leap ? 8'h29 : 8'h28;
      end
      8'h04, 8'h06, 8'h09, 8'h11: begin
        return 8'h30;
      end
      default: begin
        return 8'h31;
      end
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8+:8] = nw[i*8+:8];
      end
    end
    return r;
  endfunction

  // true when the fields chosen by the mask agree
  function automatic logic mask_hit(input logic [3:0]  m,
                                    input logic [31:0] now,
                                    input logic [31:0] at);
    case (m)
      MASK_SEC: begin
        return 1'b1;
      end
      MASK_10S: begin
        return now[SEC_LSB+:4] == at[SEC_LSB+:4];
      end
      MASK_MIN: begin
        return now[SEC_LSB+:8] == at[SEC_LSB+:8];
      end
      MASK_10M: begin
        return now[SEC_LSB+:12] == at[SEC_LSB+:12];
      end
      MASK_HOUR: begin
        return now[SEC_LSB+:16] == at[SEC_LSB+:16];
      end
      MASK_DAY: begin
        return now[SEC_LSB+:24] == at[SEC_LSB+:24];
      end
      default: begin
        return 1'b0;
      end
    endcase
  endfunction

  assign rtc_en   = st_q.on && (st_q.rdiv == DIV_LAST);
  assign hs_tick  = rtc_en && (st_q.presc == HALF_LAST);
  assign sec_tick = hs_tick && st_q.half;
  assign unsafe   = st_q.on && (st_q.presc >= SAFE_EDGE);
  assign req      = avs_read || avs_write;
  assign wr_go    = avs_write && !st_q.waitreq;

  assign c_s  = bcd_inc(st_q.tm[SEC_LSB+:8], SEC_MAX, 8'h00);
  assign c_m  = bcd_inc(st_q.tm[MIN_LSB+:8], MIN_MAX, 8'h00);
  assign c_h  = bcd_inc(st_q.tm[HR_LSB+:8], HR_MAX, 8'h00);
  assign c_d  = bcd_inc(st_q.dt[DAY_LSB+:8],
                        month_days(st_q.dt[MON_LSB+:8], st_q.dt[YR_LSB+:8]),
                        8'h01);
  assign c_mo = bcd_inc(st_q.dt[MON_LSB+:8], MON_MAX, 8'h01);
  assign c_y  = bcd_inc(st_q.dt[YR_LSB+:8], YR_MAX, 8'h00);

  always_comb begin
    st_d = st_q;
    keep = st_q;
    wv   = 32'h0000_0000;

    // next second of time and date, used for the tick and the match
    t_nx = st_q.tm;
    d_nx = st_q.dt;
    t_nx[SEC_LSB+:8] = c_s[7:0];
    if (c_s[8]) begin
      t_nx[MIN_LSB+:8] = c_m[7:0];
      if (c_m[8]) begin
        t_nx[HR_LSB+:8] = c_h[7:0];
        if (c_h[8]) begin
          d_nx[DAY_LSB+:8] = c_d[7:0];
          d_nx[WD_LSB+:4]  = (st_q.dt[WD_LSB+:4] >= WD_MAX) ? 4'h0 :
                             st_q.dt[WD_LSB+:4] + 4'h1;
          if (c_d[8]) begin
            d_nx[MON_LSB+:8] = c_mo[7:0];
            if (c_mo[8]) begin
              d_nx[YR_LSB+:8] = c_y[7:0];
            end
          end
        end
      end
    end

    // half-second mask fires on every half tick, others on seconds
    alarm_evt = st_q.alrm_en &&
                ((st_q.amask == MASK_HALF) ? hs_tick :
                 (sec_tick && mask_hit(st_q.amask, t_nx, st_q.atm)));

    ctrl_v = 32'h0000_0000;
    ctrl_v[CC_ON]     = st_q.on;
    ctrl_v[CC_UNLOCK] = st_q.unlock;
    ctrl_v[CC_SYNC]   = unsafe;
    ctrl_v[CC_HALF]   = st_q.half;
    alrm_v = 32'h0000_0000;
    alrm_v[AL_EN]         = st_q.alrm_en;
    alrm_v[AL_CHIME]      = st_q.chime;
    alrm_v[AL_PIV]        = st_q.alrm_en ? st_q.pulse : st_q.piv;
    alrm_v[AL_SYNC]       = unsafe;
    alrm_v[AL_MASK+:4]    = st_q.amask;
    alrm_v[AL_RPT+:8]     = st_q.rpt;

    case (avs_address)
      OFS_CTRL: begin
        rd_mux = ctrl_v;
      end
      OFS_ALRM: begin
        rd_mux = alrm_v;
      end
      OFS_TIME: begin
        rd_mux = st_q.tm & TIME_MASK;
      end
      OFS_DATE: begin
        rd_mux = st_q.dt & DATE_MASK;
      end
      OFS_ATIME: begin
        rd_mux = st_q.atm & TIME_MASK;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase

    // prescaler runs only while the module is on
    if (st_q.on) begin
      st_d.rdiv = rtc_en ? 10'h000 : st_q.rdiv + 10'h001;
    end
    if (rtc_en) begin
      st_d.presc = hs_tick ? 15'h0000 : st_q.presc + 15'h0001;
    end
    if (hs_tick) begin
      st_d.half = ~st_q.half;
    end
    if (sec_tick) begin
      st_d.tm = t_nx;
      st_d.dt = d_nx;
    end

    if (alarm_evt) begin
      st_d.pulse = ~st_q.pulse;
      if (st_q.rpt != 8'h00) begin
        st_d.rpt = st_q.rpt - 8'h01;
      end else if (st_q.chime) begin
        st_d.rpt = RPT_MAX;
      end else begin
        st_d.alrm_en = 1'b0;
      end
    end

    // two-phase slave: take on one edge, answer low on the next
    if (req && st_q.waitreq) begin
      st_d.waitreq = 1'b0;
      st_d.rdata   = rd_mux;
    end
    if (req && !st_q.waitreq) begin
      st_d.waitreq = 1'b1;
    end

    // a software write lands after hardware updates and wins over them
    if (wr_go) begin
      case (avs_address)
        OFS_CTRL: begin
          wv = merge(ctrl_v, avs_writedata, avs_byteenable);
          st_d.unlock = wv[CC_UNLOCK];
          if (st_q.unlock) begin
            st_d.on = wv[CC_ON];
          end
        end
        OFS_ALRM: begin
          wv = merge(alrm_v, avs_writedata, avs_byteenable);
          st_d.alrm_en = wv[AL_EN];
          st_d.chime   = wv[AL_CHIME];
          st_d.amask   = wv[AL_MASK+:4];
          st_d.rpt     = wv[AL_RPT+:8];
          if (!st_q.alrm_en) begin
            st_d.piv   = wv[AL_PIV];
          end
        end
        OFS_TIME: begin
          if (st_q.unlock) begin
            st_d.tm = merge(st_q.tm, avs_writedata, avs_byteenable) & TIME_MASK;
            // restart the second too, so the phase clear is not undone
            if (avs_byteenable[1]) begin
              st_d.half  = 1'b0;
              st_d.presc = 15'h0000;
            end
          end
        end
        OFS_DATE: begin
          if (st_q.unlock) begin
            st_d.dt = merge(st_q.dt, avs_writedata, avs_byteenable) & DATE_MASK;
          end
        end
        OFS_ATIME: begin
          st_d.atm = merge(st_q.atm, avs_writedata, avs_byteenable) & TIME_MASK;
        end
        default: begin
          st_d.on = st_q.on;
        end
      endcase
    end

    if (!st_d.alrm_en) begin
      st_d.pulse = st_d.piv;
    end

    if (por) begin
      st_d = ST_RST;
    end else if (srst) begin
      st_d         = ST_RST;
      st_d.alrm_en = keep.alrm_en;
      st_d.chime   = keep.chime;
      st_d.piv     = keep.piv;
      st_d.amask   = keep.amask;
      st_d.rpt     = keep.rpt;
      st_d.pulse   = keep.pulse;
    end
  end

  always_ff @(posedge mclk) begin
    st_q <= st_d;
  end

  assign avs_readdata    = st_q.rdata;
  assign avs_waitrequest = st_q.waitreq;
  assign alarm_pulse     = st_q.pulse;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (por || srst);

  AST_AUTO_OFF: assert property (
    alarm_evt && st_q.rpt == 8'h00 && !st_q.chime && !wr_go |=> !st_q.alrm_en)
    else $error("alarm stayed enabled after final trigger");

  AST_RPT_DEC: assert property (
    alarm_evt && st_q.rpt != 8'h00 && !wr_go |=> st_q.rpt == $past(st_q.rpt) - 8'h01)
    else $error("repeat count did not step down by one");

  AST_RPT_WRAP: assert property (
    alarm_evt && st_q.rpt == 8'h00 && st_q.chime && !wr_go |=> st_q.rpt == 8'hFF)
    else $error("repeat count did not wrap with chime");

  AST_SRST_KEEP: assert property (@(posedge mclk) disable iff (por)
    srst |=> st_q.rpt == $past(st_q.rpt) && st_q.alrm_en == $past(st_q.alrm_en))
    else $error("general reset disturbed alarm control");

  AST_LOCKED: assert property (
    wr_go && avs_address == OFS_TIME && !st_q.unlock && !sec_tick
    |=> st_q.tm == $past(st_q.tm))
    else $error("locked time register took a write");

  AST_LOW_ZERO: assert property (
    avs_read && avs_waitrequest && avs_address == OFS_TIME
    |=> !avs_waitrequest && avs_readdata[7:0] == 8'h00)
    else $error("time low byte not zero");

  AST_MIDNIGHT: assert property (
    sec_tick && st_q.tm == 32'h2359_5900 && !wr_go |=> st_q.tm == 32'h0000_0000)
    else $error("time did not roll over at midnight");

  AST_HALF_CLR: assert property (
    wr_go && avs_address == OFS_TIME && st_q.unlock && avs_byteenable[1]
    |=> !st_q.half ##1 !st_q.half)
    else $error("seconds write left half-second phase set");

  AST_SAFE_READ: assert property (
    avs_read && avs_waitrequest && avs_address == OFS_ALRM && st_q.on &&
    st_q.presc < SAFE_EDGE |=> !avs_readdata[AL_SYNC])
    else $error("alarm read flagged unsafe far from rollover");

  AST_ANSWER: assert property (
    req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("slave did not answer in one cycle");
endmodule

// ### verification/tb.sv
// self-checking testbench of the calendar and alarm register block
`timescale 1ns/10ps
module tb;
  import rtcal_pkg::*;
  localparam int unsigned HSC  = 36;
  localparam int unsigned HALF = HSC * RTC_DIV;

  logic        mclk;
  logic        srst;
  logic        por;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        alarm_pulse;
  int          errors;
  int          num_checks;
  logic [31:0] rd;
  logic [31:0] rd2;

  rtcal_regs #(.HALF_SEC_CLKS(HSC)) dut_u (
    .mclk            (mclk),
    .srst            (srst),
    .por             (por),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .alarm_pulse     (alarm_pulse)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // request stays up until the edge that samples waitrequest low
  task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                          input logic [3:0] be, output logic [31:0] q);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    @(posedge mclk);
    // no answer time assumed; only the watchdog ends a wait that never answers
    while (avs_waitrequest !== 1'b0) begin
      @(posedge mclk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic bus_write(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] dummy;
    bus_xfer(1'b1, a, d, be, dummy);
  endtask

  task automatic bus_read(input logic [4:0] a, output logic [31:0] q);
    bus_xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
  endtask

  task automatic do_reset(input logic p);
    srst <= 1'b1;
    por  <= p;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    por  <= 1'b0;
    @(posedge mclk);
  endtask

  // alarm fields are only touched while the prescaler is clear of a rollover
  task automatic wait_safe();
    int n;
    n = 0;
    bus_read(OFS_CTRL, rd);
    while (rd[CC_SYNC] !== 1'b0 && n < HALF) begin
      bus_read(OFS_CTRL, rd);
      n++;
    end
    check("sync clear before alarm write", {31'h0, rd[CC_SYNC]}, 32'h0);
  endtask

  task automatic wait_pulse();
    logic p;
    int   n;
    p = alarm_pulse;
    n = 0;
    while (alarm_pulse === p && n < HALF + 100) begin
      @(posedge mclk);
      n++;
    end
    check("alarm_pulse toggle", {31'h0, alarm_pulse}, {31'h0, ~p});
  endtask

  task automatic t_reset_values();
    check("alarm_pulse after por", {31'h0, alarm_pulse}, 32'h0000_0000);
    bus_read(OFS_ALRM, rd);
    check("alarm_control after por", rd, 32'h0000_0000);
    bus_read(5'h14, rd);
    check("unmapped read", rd, 32'h0000_0000);
    $display("test reset_values done");
  endtask

  task automatic t_srst_keeps_alarm();
    bus_write(OFS_ALRM, 32'h0000_6A05, 4'hF);
    bus_write(OFS_CTRL, 32'h0000_0008, 4'hF);
    do_reset(1'b0);
    bus_read(OFS_ALRM, rd);
    check("alarm_control after srst", rd, 32'h0000_6A05);
    bus_read(OFS_CTRL, rd);
    check("clock_control after srst", rd, 32'h0000_0000);
    bus_write(OFS_TIME, 32'h1234_5600, 4'hF);
    bus_read(OFS_TIME, rd);
    check("locked time write", rd, 32'h0000_0000);
    bus_write(OFS_DATE, 32'h1201_1503, 4'hF);
    bus_read(OFS_DATE, rd);
    check("locked date write", rd, 32'h0000_0000);
    do_reset(1'b1);
    bus_read(OFS_ALRM, rd);
    check("alarm_control after por", rd, 32'h0000_0000);
    $display("test srst_keeps_alarm done");
  endtask

  task automatic t_value_layout();
    bus_write(OFS_CTRL, 32'h0000_0008, 4'hF);
    bus_write(OFS_TIME, 32'h2359_59FF, 4'hF);
    bus_read(OFS_TIME, rd);
    check("time hours", rd[31:24], 32'h23);
    check("time minutes", rd[23:16], 32'h59);
    check("time seconds", rd[15:8], 32'h59);
    check("time low byte", rd[7:0], 32'h00);
    bus_write(OFS_DATE, 32'h9912_31F6, 4'hF);
    bus_read(OFS_DATE, rd);
    bus_read(OFS_DATE, rd2);
    check("date read twice", rd2, rd);
    check("date year", rd[31:24], 32'h99);
    check("date month", rd[23:16], 32'h12);
    check("date day", rd[15:8], 32'h31);
    check("date weekday", rd[7:0], 32'h06);
    bus_write(OFS_ATIME, 32'h1234_56AB, 4'hF);
    bus_read(OFS_ATIME, rd);
    check("alarm time", rd, 32'h1234_5600);
    $display("test value_layout done");
  endtask

  task automatic t_repeat_no_chime();
    // configured while off, so no rollover can race the write
    bus_write(OFS_ALRM, 32'h0000_8001, 4'hF);
    bus_write(OFS_CTRL, 32'h0000_8008, 4'hF);
    wait_pulse();
    bus_read(OFS_ALRM, rd);
    check("count after event 1", rd & 32'h0000_80FF, 32'h0000_8000);
    wait_safe();
    bus_write(OFS_ATIME, 32'h0000_0000, 4'hF);
    // last trigger comes only from the full time match at the coming midnight
    bus_write(OFS_ALRM, 32'h0000_8600, 4'hF);
    wait_pulse();
    bus_read(OFS_ALRM, rd);
    check("disabled after event 2", rd & 32'h0000_80FF, 32'h0000_0000);
    $display("test repeat_no_chime done");
  endtask

  task automatic t_chime_and_sync();
    wait_safe();
    bus_write(OFS_ALRM, 32'h0000_C000, 4'hF);
    wait_pulse();
    bus_read(OFS_ALRM, rd);
    check("chime wrap", rd & 32'h0000_C0FF, 32'h0000_C0FF);
    check("alarm safe after rollover", {31'h0, rd[AL_SYNC]}, 32'h0);
    bus_read(OFS_CTRL, rd);
    check("sync safe after rollover", {31'h0, rd[CC_SYNC]}, 32'h0);
    repeat (6 * RTC_DIV) @(posedge mclk);
    bus_read(OFS_ALRM, rd);
    check("alarm unsafe near rollover", {31'h0, rd[AL_SYNC]}, 32'h1);
    $display("test chime_and_sync done");
  endtask

  task automatic t_half_phase();
    int n;
    n = 0;
    bus_read(OFS_CTRL, rd);
    while (rd[CC_HALF] !== 1'b1 && n < HALF) begin
      bus_read(OFS_CTRL, rd);
      n++;
    end
    check("half phase set", {31'h0, rd[CC_HALF]}, 32'h1);
    bus_write(OFS_TIME, 32'h0000_1500, 4'h2);
    bus_read(OFS_CTRL, rd);
    check("half phase cleared", {31'h0, rd[CC_HALF]}, 32'h0);
    bus_read(OFS_TIME, rd);
    check("seconds lane write", rd, 32'h0000_1500);
    $display("test half_phase done");
  endtask

  initial begin
    errors         = 0;
    num_checks     = 0;
    srst           = 1'b1;
    por            = 1'b1;
    avs_address    = 5'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hF;
    @(posedge mclk);
    do_reset(1'b1);
    t_reset_values();
    t_srst_keeps_alarm();
    t_value_layout();
    t_repeat_no_chime();
    t_chime_and_sync();
    t_half_phase();
    finish_test();
  end

  // four half seconds plus bus traffic, with margin
  initial begin
    repeat (4 * HALF + 5000) @(posedge mclk);
    errors++;
    $display("[FAIL] watchdog expected end of tests");
    finish_test();
  end
endmodule
